// *** core/bus_byte_engine.v ***
// one byte transfer on a selected secondary bus (spi shift or i2c byte)
`timescale 1ns/10ps
`default_nettype none
module bus_byte_engine (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // request
  input  wire       start,
  input  wire       is_i2c,
  input  wire       low_bit_first,
  input  wire       cpol,
  input  wire       cpha,
  input  wire [5:0] half_div,
  input  wire [7:0] tx_byte,
  // answer
  output reg        done,
  output reg        busy,
  output reg  [7:0] rx_byte,
  output reg        nack,
  // pins
  output reg        sclk,
  output reg        mosi,
  input  wire       miso_sync,
  input  wire       ack_sync
);
  reg [7:0] shreg;
  reg [3:0] bitn;
  reg [5:0] divc;
  reg       phase;
  wire      tick = (divc == half_div);
  wire      in_bit = miso_sync;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      done    <= 1'b0;
      busy    <= 1'b0;
      rx_byte <= 8'h00;
      nack    <= 1'b0;
      sclk    <= 1'b0;
      mosi    <= 1'b0;
      shreg   <= 8'h00;
      bitn    <= 4'h0;
      divc    <= 6'h00;
      phase   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy  <= 1'b1;
        shreg <= tx_byte;
        bitn  <= 4'h0;
        divc  <= 6'h00;
        phase <= 1'b0;
        sclk  <= is_i2c ? 1'b0 : cpol;
        mosi  <= low_bit_first && !is_i2c ? tx_byte[0] : tx_byte[7];
        nack  <= 1'b0;
      end else if (busy) begin
        divc <= tick ? 6'h00 : divc + 6'h01;
        if (tick) begin
          phase <= ~phase;
          sclk  <= ~sclk;
          // sample on leading edge unless cpha moves it to trailing edge
          if (phase == (is_i2c ? 1'b0 : cpha)) begin
            if (bitn == 4'h8) begin
              nack <= is_i2c & ack_sync;
            end else if (low_bit_first && !is_i2c) begin
              shreg <= {in_bit, shreg[7:1]};
            end else begin
              shreg <= {shreg[6:0], in_bit};
            end
          end
          if (phase) begin
            bitn <= bitn + 4'h1;
            // release the data line for the target's acknowledge bit
            mosi <= (is_i2c && bitn == 4'h7) ? 1'b1
                  : (low_bit_first && !is_i2c) ? shreg[0] : shreg[7];
            if (bitn == (is_i2c ? 4'h8 : 4'h7)) begin
              busy    <= 1'b0;
              done    <= 1'b1;
              rx_byte <= shreg;
              sclk    <= is_i2c ? 1'b0 : cpol;
            end
          end
        end
      end
    end
  end
endmodule // bus_byte_engine
`default_nettype wire

// *** core/passthru_consts.vh ***
// constants for the secondary bus pass-through engine
`ifndef PASSTHRU_CONSTS_VH
`define PASSTHRU_CONSTS_VH
// mode word fields
`define MODE_DIR_BIT        0
`define MODE_SERIES_BIT     1
`define MODE_DELAY_EN_BIT   2
`define MODE_BUS_LO         3
`define MODE_BUS_HI         4
`define MODE_THREE_WIRE_BIT 5
`define MODE_CPOL_BIT       6
`define MODE_CPHA_BIT       7
`define MODE_DELAY_LO       8
`define MODE_DELAY_HI       13
`define MODE_SEL_LEVEL_BIT  14
`define MODE_LOW_FIRST_BIT  15
// command-format fields
`define FMT_SHIFT_LO        0
`define FMT_SHIFT_HI        3
`define FMT_POL_BIT         4
`define FMT_POS_LO          5
`define FMT_POS_HI          7
// delay timing
`define DELAY_UNIT_NS       50000
`define CLK_PERIOD_NS       50
`define DELAY_UNIT_CYCLES   (`DELAY_UNIT_NS / `CLK_PERIOD_NS)
`define DELAY_MIN_UNITS     6'h04
// result packet
`define RESULT_CODE         16'h0005
`define RESULT_FIXED_LEN    8'h09
`define RESULT_HDR_BYTES    8'h0D
`define DONE_OK             8'h01
`define DONE_FAIL           8'h02
`define MAX_COUNT           8'hF4
// spi divider table index count
`define DIV_CHOICES         7
`define SYS_CLK_KHZ         20000
`endif

// *** core/secondary_bus_passthrough.v ***
// pass-through transfer engine for the secondary master buses
// Functional notes
// - mode bit0 direction, bit1 burst or series
// - mode bit2 enables inter-byte delay
// - bits 8-13 delay in 50us, 0-3 invalid
// - bits 3-4 select descriptor or bus 1-3
// - bit5 selects three-wire spi, not i2c
// - bits 6,7 give spi cpol and cpha
// - bit15 shifts spi low bit first
// - register address shifted by format bits 0-3
// - format bits 5-7 place the read flag
// - format bit4 sets read flag polarity
// - target byte: i2c address or select pin
// - spi read: address write, then data transaction
// - i2c read: address write, restart, then read
// - result packet starts with code 0x0005
// - length is 9 plus count, padded
// - completion 1 ok, 2 on i2c fail
// - echo mode, format, target; rate zero on i2c
// - count at 0x0B, register 0x0C, data 0x0D
// - data padded to word, count stays genuine
// - spi clock from fixed divider set, rounded down
`timescale 1ns/10ps
`default_nettype none
`include "passthru_consts.vh"
module secondary_bus_passthrough (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // request
  input  wire        req_valid,
  output wire        req_ready,
  input  wire [15:0] req_mode,
  input  wire [15:0] req_rate_khz,
  input  wire [7:0]  req_format,
  input  wire [7:0]  req_target,
  input  wire [7:0]  req_count,
  input  wire [7:0]  req_reg,
  // write data stream
  input  wire        wdata_valid,
  input  wire [7:0]  wdata,
  output wire        wdata_ready,
  // wiring already fixed by a sensor driver
  input  wire        wiring_locked,
  input  wire        wiring_locked_three,
  // result stream
  output reg         res_valid,
  output reg  [7:0]  res_byte,
  output reg         res_last,
  input  wire        res_ready,
  // descriptor-mode hand-off
  output reg         desc_req,
  input  wire        desc_done,
  // bus pins
  output wire [2:0]  bus_active,
  output wire        sclk,
  output wire        mosi,
  output reg         three_wire,
  input  wire        miso,
  output reg  [7:0]  select_pin,
  output reg         select_out,
  output reg         sda_out,
  output reg         sda_oe_n,
  input  wire        sda_in,
  output reg         busy
);
  localparam S_IDLE  = 8'h01;
  localparam S_CMD   = 8'h02;
  localparam S_DATA  = 8'h04;
  localparam S_GAP   = 8'h08;
  localparam S_DESC  = 8'h10;
  localparam S_HDR   = 8'h20;
  localparam S_RDAT  = 8'h40;
  localparam S_PAD   = 8'h80;

  reg [7:0]  state;
  reg [15:0] mode;
  reg [15:0] rate;
  reg [7:0]  fmt;
  reg [7:0]  target;
  reg [7:0]  count;
  reg [7:0]  regaddr;
  reg [7:0]  idx;
  reg [1:0]  stage;
  reg        failed;
  reg [15:0] gap_cnt;
  reg [5:0]  gap_units;
  reg [5:0]  half_div;
  reg [7:0]  rbuf [0:255];
  reg [7:0]  hdr;
  reg [8:0]  out_len;
  reg [8:0]  pos;
  reg        eng_start;
  reg [7:0]  eng_tx;
  reg [2:0]  miso_s;
  reg [2:0]  sda_s;
  reg        miso_f;
  reg        sda_f;

  wire       is_write  = mode[`MODE_DIR_BIT];
  wire [1:0] bus_sel   = mode[`MODE_BUS_HI:`MODE_BUS_LO];
  wire       is_i2c    = (bus_sel == 2'b10);
  wire       eng_done;
  wire       eng_busy;
  wire [7:0] eng_rx;
  wire       eng_nack;
  wire [15:0] code_word = `RESULT_CODE;
  // nine bits: a full 244-byte read packet passes 255 bytes
  wire [8:0]  packet    = {1'b0, count} + {1'b0, `RESULT_FIXED_LEN} + 9'h004;
  wire [8:0]  padded    = (packet + 9'h003) & 9'h1FC;
  wire [8:0]  len_field = padded - 9'h004;
  wire [8:0]  hdr_end   = {1'b0, `RESULT_HDR_BYTES} - 9'h001;
  wire [8:0]  rd_pos    = pos - {1'b0, `RESULT_HDR_BYTES};

  assign req_ready   = (state == S_IDLE);
  assign wdata_ready = (state == S_DATA) && is_write && !eng_busy && !eng_start;
  assign bus_active  = {bus_sel == 2'b11, bus_sel == 2'b10, bus_sel == 2'b01};

  // three stages, change accepted when stages two and three agree
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      miso_s <= 3'h0;
      sda_s  <= 3'h7;
      miso_f <= 1'b0;
      sda_f  <= 1'b1;
    end else begin
      miso_s <= {miso_s[1:0], miso};
      sda_s  <= {sda_s[1:0], sda_in};
      if (miso_s[1] == miso_s[2]) begin
        miso_f <= miso_s[2];
      end
      if (sda_s[1] == sda_s[2]) begin
        sda_f <= sda_s[2];
      end
    end
  end

  // divide to half period; 2,4,4,6,8,16,32 (the divide-by-3 step gives 4), rounded to slower choice
  function [5:0] pick_half;
    input [15:0] khz;
    begin
      if (khz >= 16'h2710) begin
        pick_half = 6'h00;
      end else if (khz >= 16'h1A0A) begin
        pick_half = 6'h01;
      end else if (khz >= 16'h1388) begin
        pick_half = 6'h01;
      end else if (khz >= 16'h0D05) begin
        pick_half = 6'h02;
      end else if (khz >= 16'h09C4) begin
        pick_half = 6'h03;
      end else if (khz >= 16'h04E2) begin
        pick_half = 6'h07;
      end else begin
        pick_half = 6'h0F;
      end
    end
  endfunction

  // build the spi command byte from the format settings
  function [7:0] cmd_byte;
    input [7:0] addr;
    input [7:0] f;
    input       wr;
    reg   [7:0] b;
    reg         flag;
    begin
      b    = addr << f[`FMT_SHIFT_HI:`FMT_SHIFT_LO];
      flag = wr ? ~f[`FMT_POL_BIT] : f[`FMT_POL_BIT];
      b[f[`FMT_POS_HI:`FMT_POS_LO]] = flag;
      cmd_byte = b;
    end
  endfunction

  bus_byte_engine u_engine (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .start         (eng_start),
    .is_i2c        (is_i2c),
    .low_bit_first (mode[`MODE_LOW_FIRST_BIT]),
    .cpol          (mode[`MODE_CPOL_BIT]),
    .cpha          (mode[`MODE_CPHA_BIT]),
    .half_div      (half_div),
    .tx_byte       (eng_tx),
    .done          (eng_done),
    .busy          (eng_busy),
    .rx_byte       (eng_rx),
    .nack          (eng_nack),
    .sclk          (sclk),
    .mosi          (mosi),
    .miso_sync     (is_i2c ? sda_f : miso_f),
    .ack_sync      (sda_f)
  );

  // header byte by position in result packet
  always @* begin
    case (pos)
      9'h000:  hdr = code_word[7:0];
      9'h001:  hdr = code_word[15:8];
      9'h002:  hdr = len_field[7:0];
      9'h003:  hdr = {7'h00, len_field[8]};
      9'h004:  hdr = (failed && is_i2c) ? `DONE_FAIL : `DONE_OK;
      9'h005:  hdr = mode[7:0];
      9'h006:  hdr = mode[15:8];
      9'h007:  hdr = is_i2c ? 8'h00 : rate[7:0];
      9'h008:  hdr = is_i2c ? 8'h00 : rate[15:8];
      9'h009:  hdr = fmt;
      9'h00A:  hdr = target;
      9'h00B:  hdr = count;
      9'h00C:  hdr = regaddr;
      default: hdr = 8'h00;
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state      <= S_IDLE;
      mode       <= 16'h0000;
      rate       <= 16'h0000;
      fmt        <= 8'h00;
      target     <= 8'h00;
      count      <= 8'h00;
      regaddr    <= 8'h00;
      idx        <= 8'h00;
      stage      <= 2'b00;
      failed     <= 1'b0;
      gap_cnt    <= 16'h0000;
      gap_units  <= 6'h00;
      half_div   <= 6'h00;
      out_len    <= 9'h000;
      pos        <= 9'h000;
      eng_start  <= 1'b0;
      eng_tx     <= 8'h00;
      res_valid  <= 1'b0;
      res_byte   <= 8'h00;
      res_last   <= 1'b0;
      desc_req   <= 1'b0;
      three_wire <= 1'b0;
      select_pin <= 8'h00;
      select_out <= 1'b0;
      sda_out    <= 1'b1;
      sda_oe_n   <= 1'b1;
      busy       <= 1'b0;
    end else begin
      eng_start <= 1'b0;
      // open drain: pull low only while a zero bit is on the wire
      sda_oe_n  <= !(is_i2c && eng_busy && !mosi);
      case (state)
        S_IDLE: begin
          busy <= 1'b0;
          if (req_valid) begin
            mode     <= req_mode;
            rate     <= req_rate_khz;
            fmt      <= req_format;
            target   <= req_target;
            count    <= (req_count > `MAX_COUNT) ? `MAX_COUNT : req_count;
            regaddr  <= req_reg;
            half_div <= pick_half(req_rate_khz);
            failed   <= 1'b0;
            idx      <= 8'h00;
            pos      <= 9'h000;
            stage    <= 2'b00;
            select_out <= ~req_mode[`MODE_SEL_LEVEL_BIT];
            busy     <= 1'b1;
            // delay values below four are invalid: clamp to minimum
            gap_units <= (req_mode[`MODE_DELAY_HI:`MODE_DELAY_LO] < `DELAY_MIN_UNITS)
                         ? `DELAY_MIN_UNITS : req_mode[`MODE_DELAY_HI:`MODE_DELAY_LO];
            if (!wiring_locked) begin
              three_wire <= req_mode[`MODE_THREE_WIRE_BIT];
            end else begin
              three_wire <= wiring_locked_three;
            end
            select_pin <= req_target;
            if (req_mode[`MODE_BUS_HI:`MODE_BUS_LO] == 2'b00) begin
              desc_req <= 1'b1;
              state    <= S_DESC;
            end else begin
              state <= S_CMD;
            end
          end
        end
        S_DESC: begin
          if (desc_done) begin
            desc_req <= 1'b0;
            idx      <= 8'h00;
            state    <= S_HDR;
          end
        end
        S_CMD: begin
          // stage 0 address byte / i2c target, stage 1 register, stage 2 read phase
          if (!eng_busy && !eng_start) begin
            if (stage == 2'b00) begin
              select_out <= is_i2c ? select_out : mode[`MODE_SEL_LEVEL_BIT];
              sda_out    <= 1'b0;
              eng_tx     <= is_i2c ? {target[6:0], 1'b0}
                                   : cmd_byte(regaddr, fmt, is_write);
              eng_start  <= 1'b1;
              stage      <= is_i2c ? 2'b01 : 2'b11;
            end else if (stage == 2'b01) begin
              eng_tx    <= regaddr;
              eng_start <= 1'b1;
              stage     <= 2'b10;
            end else if (stage == 2'b10) begin
              if (is_i2c && !is_write) begin
                // repeated start without stop, then address in read mode
                eng_tx    <= {target[6:0], 1'b1};
                eng_start <= 1'b1;
              end
              stage <= 2'b11;
            end else begin
              if (!is_i2c && !is_write) begin
                // end the address write; data read is its own transaction
                select_out <= ~mode[`MODE_SEL_LEVEL_BIT];
              end
              idx   <= 8'h00;
              state <= S_DATA;
            end
          end
          if (eng_done && eng_nack) begin
            failed <= 1'b1;
          end
        end
        S_DATA: begin
          if (!eng_busy && !eng_start && idx == count) begin
            select_out <= ~mode[`MODE_SEL_LEVEL_BIT];
            idx        <= 8'h00;
            state      <= S_HDR;
          end else if (!eng_busy && !eng_start) begin
            if (!is_write) begin
              select_out <= is_i2c ? select_out : mode[`MODE_SEL_LEVEL_BIT];
              eng_tx     <= 8'hFF;
              eng_start  <= 1'b1;
            end else if (wdata_valid) begin
              select_out <= is_i2c ? select_out : mode[`MODE_SEL_LEVEL_BIT];
              eng_tx    <= wdata;
              eng_start <= 1'b1;
            end
          end
          if (eng_done) begin
            if (eng_nack) begin
              failed <= 1'b1;
            end
            if (!is_write) begin
              rbuf[idx] <= eng_rx;
            end
            idx <= idx + 8'h01;
            if (mode[`MODE_SERIES_BIT]) begin
              select_out <= ~mode[`MODE_SEL_LEVEL_BIT];
            end
            if (mode[`MODE_DELAY_EN_BIT]) begin
              gap_cnt <= 16'h0000;
              state   <= S_GAP;
            end
          end
        end
        S_GAP: begin
          gap_cnt <= gap_cnt + 16'h0001;
          if (gap_cnt == gap_units * `DELAY_UNIT_CYCLES - 1) begin
            state <= S_DATA;
          end
        end
        S_HDR: begin
          if (!res_valid || res_ready) begin
            res_valid <= 1'b1;
            res_byte  <= hdr;
            out_len   <= padded;
            res_last  <= 1'b0;
            pos       <= pos + 9'h001;
            if (pos == hdr_end) begin
              // writes, empty reads and descriptor hand-off carry no data bytes
              state <= (is_write || count == 8'h00 || bus_sel == 2'b00) ? S_PAD : S_RDAT;
            end
          end
        end
        S_RDAT: begin
          if (res_ready) begin
            res_byte <= rbuf[rd_pos[7:0]];
            res_last <= (pos == out_len - 9'h001);
            pos      <= pos + 9'h001;
            if (pos == hdr_end + {1'b0, count}) begin
              state <= S_PAD;
            end
          end
        end
        S_PAD: begin
          if (res_ready) begin
            if (res_last) begin
              res_valid <= 1'b0;
              res_last  <= 1'b0;
              busy      <= 1'b0;
              state     <= S_IDLE;
            end else begin
              res_byte <= 8'h00;
              res_last <= (pos == out_len - 9'h001);
              pos      <= pos + 9'h001;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // secondary_bus_passthrough
`default_nettype wire

// *** verif/bus_target_model.sv ***
// far-side model: an spi target and an i2c target on the secondary buses
`timescale 1ns/10ps
`default_nettype none
module bus_target_model (
  // clock
  input  wire logic clk_sys,
  // spi side
  input  wire logic select_out,
  input  wire logic sel_level,
  output wire logic miso,
  // i2c side
  input  wire logic sda_out,
  input  wire logic sda_oe_n,
  input  wire logic nack_mode,
  output wire logic sda_in
);
  logic idle_pat = 1'b0;
  always @(posedge clk_sys) begin
    idle_pat <= ~idle_pat;
  end
  // unselected target leaves a toggling line, so a wrong select level shows in the data
  assign miso = (select_out === sel_level) ? 1'b1 : idle_pat;
  // target pulls low to acknowledge and reads as zeros; pull-up when it stays silent
  assign sda_in = !sda_oe_n ? sda_out : !nack_mode ? 1'b0 : 1'b1;
endmodule // bus_target_model
`default_nettype wire

// *** verif/passthru_sva.sv ***
// assertion checker for the pass-through engine ports
`timescale 1ns/10ps
`default_nettype none
module passthru_sva (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // request and result
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic       res_valid,
  input wire logic [7:0] res_byte,
  input wire logic       res_last,
  input wire logic       res_ready,
  // bus side
  input wire logic       desc_req,
  input wire logic [2:0] bus_active,
  input wire logic       sda_oe_n,
  input wire logic [7:0] select_pin,
  input wire logic       busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // packet byte position
  // ----------------------------------------
  logic [8:0] idx;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idx <= 9'h000;
    end else if (res_valid && res_ready) begin
      idx <= res_last ? 9'h000 : idx + 9'h001;
    end
  end
  code_low_a: assert property (res_valid && idx == 9'h000 |-> res_byte == 8'h05)
    else $error("status code low byte wrong");
  code_high_a: assert property (res_valid && idx == 9'h001 |-> res_byte == 8'h00)
    else $error("status code high byte wrong");
  pad_end_a: assert property (res_valid && res_last |-> idx[1:0] == 2'b11)
    else $error("packet not a multiple of four");
  res_hold_a: assert property (res_valid && !res_ready |=>
    res_valid && $stable(res_byte) && $stable(res_last)) else $error("result byte dropped");
  refuse_busy_a: assert property (busy |-> !req_ready)
    else $error("request taken while busy");
  take_start_a: assert property (req_valid && req_ready |=> busy)
    else $error("accepted request did not start");
  bus_onehot_a: assert property ($onehot0(bus_active))
    else $error("more than one bus active");
  sda_i2c_a: assert property (!sda_oe_n |-> bus_active == 3'b010)
    else $error("data line driven off the i2c bus");
  desc_only_a: assert property (desc_req |-> bus_active == 3'b000)
    else $error("descriptor hand-off with a raw bus");
  select_hold_a: assert property (busy && $past(busy) |-> $stable(select_pin))
    else $error("select pin moved mid transfer");
  release_a: assert property (res_valid && res_ready && res_last |=> ##[0:3] req_ready)
    else $error("engine stuck after packet");
  cover property (res_valid && res_ready && res_last);
  cover property (desc_req);
  cover property (!sda_oe_n);
endmodule // passthru_sva
bind secondary_bus_passthrough passthru_sva u_passthru_sva (
  .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
  .res_valid(res_valid), .res_byte(res_byte), .res_last(res_last), .res_ready(res_ready),
  .desc_req(desc_req), .bus_active(bus_active), .sda_oe_n(sda_oe_n),
  .select_pin(select_pin), .busy(busy));
`default_nettype wire

// *** verif/tb_secondary_bus_passthrough.sv ***
// self-checking bench for the secondary bus pass-through engine
`timescale 1ns/10ps
`default_nettype none
module tb_secondary_bus_passthrough;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  logic [15:0] req_mode = 16'h0000;
  logic [15:0] req_rate_khz = 16'h0000;
  logic [7:0]  req_format = 8'h00;
  logic [7:0]  req_target = 8'h00;
  logic [7:0]  req_count = 8'h00;
  logic [7:0]  req_reg = 8'h00;
  logic        wdata_valid = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic        res_ready = 1'b0;
  logic        desc_done = 1'b0;
  logic        nack_mode = 1'b0;
  logic        locked = 1'b0;
  wire         req_ready, wdata_ready, res_valid, res_last, desc_req, sclk, mosi;
  wire         three_wire, miso, select_out, sda_out, sda_oe_n, sda_in, busy;
  wire  [7:0]  res_byte, select_pin;
  wire  [2:0]  bus_active;
  int          err_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          n;
  logic [7:0]  pkt [0:271];
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  always @(posedge clk_sys) desc_done <= desc_req & ~desc_done;
  secondary_bus_passthrough u_secondary_bus_passthrough (
    .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_mode(req_mode), .req_rate_khz(req_rate_khz), .req_format(req_format),
    .req_target(req_target), .req_count(req_count), .req_reg(req_reg),
    .wdata_valid(wdata_valid), .wdata(wdata), .wdata_ready(wdata_ready),
    .wiring_locked(locked), .wiring_locked_three(locked), .res_valid(res_valid),
    .res_byte(res_byte), .res_last(res_last), .res_ready(res_ready), .desc_req(desc_req),
    .desc_done(desc_done), .bus_active(bus_active), .sclk(sclk), .mosi(mosi),
    .three_wire(three_wire), .miso(miso), .select_pin(select_pin),
    .select_out(select_out), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sda_in(sda_in),
    .busy(busy));
  bus_target_model u_bus_target_model (
    .clk_sys(clk_sys), .select_out(select_out), .sel_level(req_mode[14]), .miso(miso),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .nack_mode(nack_mode), .sda_in(sda_in));
  // ----------------------------------------
  // checking and transfer tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one whole pass-through: request, write bytes, then the result packet
  task automatic run(input logic [15:0] m, input logic [15:0] r, input logic [7:0] f,
                     input logic [7:0] t, input logic [7:0] c, input logic [7:0] st,
                     input int gap);
    int t0, lp, w;
    logic rd;
    logic [7:0] d;
    rd = !m[0] && m[4:3] != 2'b00;
    d = (m[4:3] == 2'b10) ? 8'h00 : 8'hFF;
    lp = ((9 + c + 7) / 4) * 4 - 4;
    req_mode <= m;
    req_rate_khz <= r;
    req_format <= f;
    req_target <= t;
    req_count <= c;
    req_reg <= f ^ t;
    req_valid <= 1'b1;
    w = 0;
    do @(posedge clk_sys); while (req_ready !== 1'b1 && ++w < 100);
    req_valid <= 1'b0;
    t0 = cyc;
    for (int i = 0; i < c && m[0]; i++) begin
      wdata_valid <= 1'b1;
      wdata <= 8'hA0 + i[7:0];
      do @(posedge clk_sys); while (wdata_ready !== 1'b1 && ++w < 20000);
    end
    wdata_valid <= 1'b0;
    n = 0;
    while (w < 20000 && n < 272) begin
      res_ready <= ~res_ready;
      @(posedge clk_sys);
      w++;
      if (res_valid === 1'b1 && res_ready) begin
        pkt[n] = res_byte;
        n++;
        if (res_last) break;
      end
    end
    res_ready <= 1'b0;
    chk(16'(w < 20000), 16'h0001, "packet done");
    chk({pkt[1], pkt[0]}, 16'h0005, "code");
    chk({pkt[3], pkt[2]}, 16'(lp), "length");
    chk(pkt[4], st, "status");
    chk({pkt[6], pkt[5]}, m, "mode");
    chk({pkt[8], pkt[7]}, m[4:3] == 2'b10 ? 16'h0000 : r, "rate");
    chk(pkt[9], f, "format");
    chk(pkt[10], t, "target");
    chk(pkt[11], c, "count");
    chk(pkt[12], f ^ t, "register");
    if (rd) begin
      chk(16'(n), 16'(lp + 4), "size");
      for (int i = 13; i < n; i++) chk(pkt[i], i < 13 + c ? d : 8'h00, "data");
    end
    chk(16'((cyc - t0) >= gap * c), 16'h0001, "byte gap");
    $display("test done mode %h count %0d", m, c);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk({busy, res_valid, req_ready, sda_out, sda_oe_n}, 16'h0007, "reset");
    run(16'hC0EB, 16'h09C4, 8'hE1, 8'h05, 8'h03, 8'h01, 0);
    run(16'h021C, 16'h2710, 8'h10, 8'h03, 8'h02, 8'h01, 4000);
    run(16'h0010, 16'h0064, 8'h00, 8'h48, 8'h01, 8'h01, 0);
    nack_mode <= 1'b1;
    run(16'h0011, 16'h0064, 8'h00, 8'h49, 8'h02, 8'h02, 0);
    nack_mode <= 1'b0;
    run(16'h0000, 16'h0064, 8'h07, 8'h01, 8'h01, 8'h01, 0);
    run(16'h8008, 16'h2710, 8'hA0, 8'h02, 8'hF4, 8'h01, 0);
    final_report;
  end
  initial begin
    #3000000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report;
  end
endmodule // tb_secondary_bus_passthrough
`default_nettype wire
